// ### ddr_io_consts.vh
/*
 * register offsets, field positions, reset values and timing counts
 * for the ddr i/o block; assumes a 20 MHz system clock.
 */
`ifndef DDR_IO_CONSTS_VH
`define DDR_IO_CONSTS_VH
// register byte offsets
`define A_CTRL 8'h00
`define A_DLY 8'h04
`define A_WIDTH 8'h08
`define A_GRP 8'h0C
`define A_FREQ 8'h10
`define A_STAT 8'h14
`define A_CMD 8'h18
// control fields
`define F_DIR 1:0
`define F_GEAR2X 2
`define F_SINGLE 3
`define F_LOCAL_SET 4
`define F_CKE_EN 5
`define F_DQ_TS 6
`define F_DQS_TS 7
`define F_MEM 8
`define F_DDR2 9
`define F_DIFF 10
`define F_JIT_HI 11
`define CTRL_RST 12'h8C0
// directions
`define DIR_IN 2'h0
`define DIR_OUT 2'h1
`define DIR_BIDI 2'h2
`define DIR_TRI 2'h3
// delay fields and modes
`define F_DMODE 1:0
`define F_MULT 5:2
`define F_DYN 9:6
`define DM_DYN 2'h0
`define DM_FIX 2'h1
`define DM_XGMII 2'h2
`define XGMII_TAP 4'h0
`define DLY_RST 10'h000
// defaults and limits
`define WIDTH_RST 7'h08
`define WIDTH_MAX 7'h40
`define GRP_RST 4'h1
`define FREQ_RST 9'h0C8
`define DDR_FMIN 9'h064
`define DDR_FMAX 9'h0C8
`define DDR2_FMIN 9'h0A6
`define DDR2_FMAX 9'h10A
`define JIT_ADVISE 9'h096
// timing
`define CLK_NS 50
`define DLL_LOCK_HI_NS 1600
`define DLL_LOCK_LO_NS 800
`define LOCK_HI_CYC (`DLL_LOCK_HI_NS / `CLK_NS)
`define LOCK_LO_CYC (`DLL_LOCK_LO_NS / `CLK_NS)
`define DQS_HALF_NS 200
`define DQS_HALF_CYC (`DQS_HALF_NS / `CLK_NS)
`endif

// ### ddr_io.v
/*
 * ddr i/o block: register file, input capture with delay line, output
 * serialiser with strobe generator, dll lock model and receive fifo.
 * assumes the strobe and data pins are asynchronous to clk and much
 * slower than it (strobe period at least 8 clk cycles).
 */
`timescale 1ns/1ps
`default_nettype none
`include "ddr_io_consts.vh"

// receive fifo with a registered output stage
module ddr_fifo #(parameter W = 32, parameter D = 8, parameter AW = 3)
(
   // clock and reset
   input wire clk,
   input wire reset_n,
   // fill side
   input wire [W-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   // drain side
   output reg [W-1:0] out_data_ff,
   output reg out_valid_ff,
   input wire out_ready,
   // level flags
   output wire full,
   output wire empty
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wp_ff;
   reg [AW-1:0] rp_ff;
   reg [AW:0] cnt_ff;
   wire push;
   wire pop;
   assign full = (cnt_ff == D);
   assign empty = (cnt_ff == 0);
   assign in_ready = !full;
   assign push = in_valid && !full;
   assign pop = !empty && (!out_valid_ff || out_ready);
   // storage and pointers
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         wp_ff <= {AW{1'b0}};
         rp_ff <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
         out_valid_ff <= 1'b0;
         out_data_ff <= {W{1'b0}};
      end
      else
      begin
         if (push)
         begin
            mem[wp_ff] <= in_data;
            wp_ff <= wp_ff + 1'b1;
         end
         if (pop)
         begin
            out_data_ff <= mem[rp_ff];
            rp_ff <= rp_ff + 1'b1;
         end
         if (pop)
            out_valid_ff <= 1'b1;
         else if (out_ready)
            out_valid_ff <= 1'b0;
         cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

module ddr_io
(
   // clock and reset
   input wire clk,
   input wire reset_n,
   // register port
   input wire [7:0] addr,
   input wire [31:0] wr_data,
   input wire wr_en,
   input wire rd_en,
   output reg [31:0] rd_data_ff,
   // pins
   input wire dqs_in,
   input wire [7:0] dq_in,
   output reg [7:0] dq_out_ff,
   output reg dq_oe_n_ff,
   output reg dqs_out_ff,
   output reg dqs_oe_n_ff,
   output reg dqs_n_out_ff,
   output reg dqs_n_oe_n_ff,
   // fabric controls
   input wire cke,
   input wire dq_ts,
   input wire dqs_ts,
   // fabric transmit
   input wire [31:0] tx_data,
   input wire tx_valid,
   output reg tx_ready_ff,
   // fabric receive
   output wire [31:0] rx_data,
   output wire rx_valid,
   input wire rx_ready
);
   reg [11:0] ctrl_ff;
   reg [9:0] dly_ff;
   reg [6:0] width_ff;
   reg [3:0] grp_ff;
   reg [8:0] freq_ff;
   reg cfg_err_ff;
   reg ovf_ff;
   reg [7:0] lock_cnt_ff;
   reg lock_ff;
   reg dqs_s1_ff, dqs_s2_ff, dqs_s3_ff;
   reg [7:0] dq_s1_ff, dq_s2_ff;
   reg [7:0] dl_ff [0:15];
   reg [7:0] rise_ff, fall_ff;
   reg [15:0] half_ff;
   reg half_v_ff;
   reg pend_ff;
   reg [31:0] cap_ff;
   reg cap_v_ff;
   reg [2:0] div_ff;
   reg [1:0] ph_ff;
   reg [31:0] hold_ff;
   reg hold_v_ff;
   reg [31:0] nxt_hold;
   reg nxt_hold_v;
   reg [1:0] nxt_ph;
   reg [31:0] rd_mux;
   wire [1:0] dir;
   wire gear2x;
   wire dly_on;
   wire [3:0] tap;
   wire [7:0] lane_mask;
   wire [7:0] tap_data;
   wire rise_ev, fall_ev;
   wire cap_en;
   wire set_reset_pulse;
   wire [7:0] set_reset_val;
   wire in_ready;
   wire fifo_full, fifo_empty;
   wire freq_ok;
   wire [8:0] wfreq;
   wire tick;
   wire [1:0] ph_last;
   wire wr_ctrl, wr_freq, wr_stat;
   integer i;

   // memory flavour is always a bidirectional 1x data path
   assign dir = ctrl_ff[`F_MEM] ? `DIR_BIDI : ctrl_ff[`F_DIR];
   assign gear2x = ctrl_ff[`F_GEAR2X] &&
      (dir == `DIR_IN || dir == `DIR_OUT);
   assign dly_on = (dir == `DIR_IN || dir == `DIR_BIDI);
   // delay tap selection; multiplier only counts in fixed mode
   assign tap = !dly_on ? 4'h0 :
      (dly_ff[`F_DMODE] == `DM_FIX) ? dly_ff[`F_MULT] :
      (dly_ff[`F_DMODE] == `DM_XGMII) ? `XGMII_TAP :
      dly_ff[`F_DYN];
   // lanes above the configured width read and drive zero
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : lanes
         assign lane_mask[g] = (width_ff > g);
      end
   endgenerate
   assign tap_data = dl_ff[tap] & lane_mask;
   assign rise_ev = dqs_s2_ff && !dqs_s3_ff;
   assign fall_ev = !dqs_s2_ff && dqs_s3_ff;
   // capture stalls while the fifo is full; a half word already held is kept
   assign cap_en = dly_on && in_ready &&
      (!ctrl_ff[`F_CKE_EN] || cke);
   assign set_reset_pulse = wr_en && (addr == `A_CMD) && wr_data[0];
   assign set_reset_val = {8{ctrl_ff[`F_LOCAL_SET]}};
   assign wr_ctrl = wr_en && (addr == `A_CTRL);
   assign wr_freq = wr_en && (addr == `A_FREQ);
   assign wr_stat = wr_en && (addr == `A_STAT);
   assign wfreq = wr_data[8:0];
   assign freq_ok = ctrl_ff[`F_DDR2] ?
      (wfreq >= `DDR2_FMIN && wfreq <= `DDR2_FMAX) :
      (wfreq >= `DDR_FMIN && wfreq <= `DDR_FMAX);
   assign tick = (div_ff == `DQS_HALF_CYC - 1);
   assign ph_last = gear2x ? 2'h3 : 2'h1;

   // configuration registers; bad width, group and frequency values are refused, only bad group and frequency values flagged
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         ctrl_ff <= `CTRL_RST;
         dly_ff <= `DLY_RST;
         width_ff <= `WIDTH_RST;
         grp_ff <= `GRP_RST;
         freq_ff <= `FREQ_RST;
         cfg_err_ff <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_ff <= wr_data[11:0];
         if (wr_en && addr == `A_DLY)
            dly_ff <= wr_data[9:0];
         if (wr_en && addr == `A_WIDTH && wr_data[6:0] != 7'h00 &&
            wr_data[6:0] <= `WIDTH_MAX)
            width_ff <= wr_data[6:0];
         if (wr_en && addr == `A_GRP && (wr_data[3:0] == 4'h1 ||
            wr_data[3:0] == 4'h2 || wr_data[3:0] == 4'h4 ||
            wr_data[3:0] == 4'h8))
            grp_ff <= wr_data[3:0];
         if (wr_freq && freq_ok)
            freq_ff <= wfreq;
         // an error in the same cycle as its clear still sets
         if ((wr_freq && !freq_ok) || (wr_en && addr == `A_GRP &&
            wr_data[3:0] != 4'h1 && wr_data[3:0] != 4'h2 &&
            wr_data[3:0] != 4'h4 && wr_data[3:0] != 4'h8))
            cfg_err_ff <= 1'b1;
         else if (wr_stat && wr_data[1])
            cfg_err_ff <= 1'b0;
      end
   end

   // dll lock model: relocks after a frequency or sensitivity change
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         lock_cnt_ff <= 8'h00;
         lock_ff <= 1'b0;
      end
      else if ((wr_freq && freq_ok) || wr_ctrl)
      begin
         lock_cnt_ff <= 8'h00;
         lock_ff <= 1'b0;
      end
      else if (!lock_ff)
      begin
         lock_cnt_ff <= lock_cnt_ff + 8'h01;
         if (lock_cnt_ff == (ctrl_ff[`F_JIT_HI] ? `LOCK_HI_CYC - 1 :
            `LOCK_LO_CYC - 1))
            lock_ff <= 1'b1;
      end
   end

   // pin synchronisers and the input delay line
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         dqs_s1_ff <= 1'b0;
         dqs_s2_ff <= 1'b0;
         dqs_s3_ff <= 1'b0;
         dq_s1_ff <= 8'h00;
         dq_s2_ff <= 8'h00;
         for (i = 0; i < 16; i = i + 1)
            dl_ff[i] <= 8'h00;
      end
      else
      begin
         dqs_s1_ff <= dqs_in;
         dqs_s2_ff <= dqs_s1_ff;
         dqs_s3_ff <= dqs_s2_ff;
         dq_s1_ff <= dq_in;
         dq_s2_ff <= dq_s1_ff;
         dl_ff[0] <= dq_s2_ff;
         for (i = 1; i < 16; i = i + 1)
            dl_ff[i] <= dl_ff[i-1];
      end
   end

   // double-edge capture and gearing into fabric words
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         rise_ff <= 8'h00;
         fall_ff <= 8'h00;
         half_ff <= 16'h0000;
         half_v_ff <= 1'b0;
         pend_ff <= 1'b0;
         cap_ff <= 32'h0000_0000;
         cap_v_ff <= 1'b0;
         ovf_ff <= 1'b0;
      end
      else
      begin
         cap_v_ff <= 1'b0;
         if (set_reset_pulse)
         begin
            rise_ff <= set_reset_val;
            fall_ff <= set_reset_val;
            half_v_ff <= 1'b0;
            pend_ff <= 1'b0;
         end
         else if (cap_en)
         begin
            if (rise_ev)
               rise_ff <= tap_data;
            if (fall_ev)
               fall_ff <= tap_data;
            // in 1x, the single-clock option hands the pair over on the next rise
            if (fall_ev && !(ctrl_ff[`F_SINGLE] && !gear2x))
               pend_ff <= 1'b1;
            else if (rise_ev && ctrl_ff[`F_SINGLE] && !gear2x)
               pend_ff <= 1'b1;
            if (pend_ff)
            begin
               pend_ff <= 1'b0;
               if (gear2x && !half_v_ff)
               begin
                  half_ff <= {fall_ff, rise_ff};
                  half_v_ff <= 1'b1;
               end
               else
               begin
                  cap_ff <= gear2x ? {fall_ff, rise_ff, half_ff} :
                     {16'h0000, fall_ff, rise_ff};
                  cap_v_ff <= 1'b1;
                  half_v_ff <= 1'b0;
               end
            end
         end
         // edges lost while the fifo is full raise a sticky flag
         if (dly_on && !in_ready && (rise_ev || fall_ev))
            ovf_ff <= 1'b1;
         else if (wr_stat && wr_data[2])
            ovf_ff <= 1'b0;
      end
   end

   ddr_fifo #(.W(32), .D(8), .AW(3)) rx_fifo
   (
      .clk(clk),
      .reset_n(reset_n),
      .in_data(cap_ff),
      .in_valid(cap_v_ff),
      .in_ready(in_ready),
      .out_data_ff(rx_data),
      .out_valid_ff(rx_valid),
      .out_ready(rx_ready),
      .full(fifo_full),
      .empty(fifo_empty)
   );

   // transmit holding word and phase sequencing
   always @*
   begin
      nxt_hold = hold_ff;
      nxt_hold_v = hold_v_ff;
      nxt_ph = ph_ff;
      if (tick && dir != `DIR_IN && hold_v_ff)
      begin
         if (ph_ff == ph_last)
         begin
            nxt_ph = 2'h0;
            nxt_hold_v = 1'b0;
         end
         else
            nxt_ph = ph_ff + 2'h1;
      end
      if (tx_valid && tx_ready_ff)
      begin
         nxt_hold = tx_data;
         nxt_hold_v = 1'b1;
      end
   end

   // strobe divider and output pins; each phase goes out on a strobe toggle, rise or fall
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         div_ff <= 3'h0;
         ph_ff <= 2'h0;
         hold_ff <= 32'h0000_0000;
         hold_v_ff <= 1'b0;
         tx_ready_ff <= 1'b0;
         dq_out_ff <= 8'h00;
         dqs_out_ff <= 1'b0;
         dq_oe_n_ff <= 1'b1;
         dqs_oe_n_ff <= 1'b1;
         dqs_n_out_ff <= 1'b1;
         dqs_n_oe_n_ff <= 1'b1;
      end
      else
      begin
         div_ff <= tick ? 3'h0 : div_ff + 3'h1;
         hold_ff <= nxt_hold;
         hold_v_ff <= nxt_hold_v;
         ph_ff <= nxt_ph;
         tx_ready_ff <= !nxt_hold_v && dir != `DIR_IN;
         if (tick && dir != `DIR_IN)
         begin
            dqs_out_ff <= !dqs_out_ff;
            dqs_n_out_ff <= dqs_out_ff;
            dq_out_ff <= hold_v_ff ?
               hold_ff[{ph_ff, 3'h0} +: 8] & lane_mask : 8'h00;
         end
         dq_oe_n_ff <= (dir == `DIR_IN) ||
            (ctrl_ff[`F_DQ_TS] && dq_ts);
         dqs_oe_n_ff <= (dir == `DIR_IN) ||
            (ctrl_ff[`F_DQS_TS] && dqs_ts);
         dqs_n_oe_n_ff <= (dir == `DIR_IN) ||
            (ctrl_ff[`F_DQS_TS] && dqs_ts) ||
            !(ctrl_ff[`F_DDR2] && ctrl_ff[`F_DIFF]);
      end
   end

   // read mux; unmapped offsets read zero
   always @*
   begin
      case (addr)
         `A_CTRL: rd_mux = {20'h0_0000, ctrl_ff};
         `A_DLY: rd_mux = {22'h00_0000, dly_ff};
         `A_WIDTH: rd_mux = {25'h000_0000, width_ff};
         `A_GRP: rd_mux = {28'h000_0000, grp_ff};
         `A_FREQ: rd_mux = {23'h00_0000, freq_ff};
         `A_STAT: rd_mux = {26'h000_0000, fifo_full, fifo_empty,
            (freq_ff >= `JIT_ADVISE) && !ctrl_ff[`F_JIT_HI],
            ovf_ff, cfg_err_ff, lock_ff};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always @(posedge clk)
   begin
      if (!reset_n)
         rd_data_ff <= 32'h0000_0000;
      else
         rd_data_ff <= rd_en ? rd_mux : 32'h0000_0000;
   end
endmodule
`default_nettype wire

// ### ddr_io_chk.sv
/* port checker for ddr_io: register refusals, strobe pacing, streams.
   assumes it is bound to the ddr_io top and reset_n is synchronous. */
`timescale 1ns/1ps
`default_nettype none
module ddr_io_chk
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rd_data_ff,
   // pins
   input wire logic [7:0] dq_out_ff,
   input wire logic dqs_out_ff,
   // fabric streams
   input wire logic tx_valid,
   input wire logic tx_ready_ff,
   input wire logic [31:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_ready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // legal widths read back; a zero width or a group count of three is not taken
   width_readback_a: assert property (
      wr_en && addr == 8'h08 && wr_data > 0 && wr_data <= 32'h0000_0040
      ##2 rd_en && addr == 8'h08 |=> rd_data_ff == $past(wr_data, 3))
      else $error("width readback differs");
   width_refuse_a: assert property (
      wr_en && addr == 8'h08 && wr_data == 0
      ##2 rd_en && addr == 8'h08 |=> rd_data_ff != 32'h0)
      else $error("zero width taken");
   grp_refuse_a: assert property (
      wr_en && addr == 8'h0c && wr_data == 32'h3
      ##2 rd_en && addr == 8'h0c |=> rd_data_ff != 32'h3)
      else $error("group count three taken");

   // strobe and data leave on divider ticks four clocks apart
   dqs_period_a: assert property (
      $changed(dqs_out_ff) |=> $stable(dqs_out_ff) [*3])
      else $error("strobe toggled early");
   dq_hold_a: assert property (
      $changed(dq_out_ff) |=> $stable(dq_out_ff) [*3])
      else $error("data pins changed early");
   tx_gap_a: assert property (
      tx_valid && tx_ready_ff |=> !tx_ready_ff [*4])
      else $error("next word taken before both phases");

   // received word waits for the drain and is 1x shaped
   rx_hold_a: assert property (
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("received word dropped while stalled");
   rx_upper_a: assert property (
      rx_valid |-> rx_data[31:16] == 16'h0000)
      else $error("1x word has upper half set");

   // main scenarios
   cover property (rx_valid && rx_ready);
   cover property (tx_valid && tx_ready_ff);
   cover property (wr_en && addr == 8'h0c ##2 rd_en);
endmodule
`default_nettype wire

// ### ddr_pins_model.sv
/* far-side pins: strobe and data frames at a strobe period of 413 ns or more.
   assumes only the bench calls send_pair, one frame at a time. */
`timescale 1ns/1ps
`default_nettype none
module ddr_pins_model
(
   // pins toward the block
   output logic dqs_in,
   output logic [7:0] dq_in
);
   // strobe rests low between frames
   initial
   begin
      dqs_in = 1'b0;
      dq_in = 8'h5a;
   end

   // data centred on each strobe edge; offset keeps edges off clk
   task automatic send_pair(input logic [7:0] r, input logic [7:0] f);
      begin
         #13 dq_in = r;
         #100 dqs_in = 1'b1;
         #100 dq_in = f;
         #100 dqs_in = 1'b0;
         #100 dq_in = ~f; // stale data never looks valid
      end
   endtask
endmodule
`default_nettype wire

// ### tb_ddr_io.sv
/* bench for ddr_io: register table, receive, fill, transmit.
   assumes ddr_io.v, ddr_io_chk.sv and ddr_pins_model.sv. */
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_io;
   logic clk, reset_n, wr_en, rd_en, cke, dq_ts, dqs_ts, tx_valid;
   logic rx_ready, tx_ready_ff, rx_valid, dqs_in, drain;
   logic dq_oe_n_ff, dqs_out_ff, dqs_oe_n_ff;
   logic [7:0] addr, dq_in, dq_out_ff;
   logic [31:0] wr_data, rd_data_ff, tx_data, rx_data, w;
   logic [31:0] exp_q[$];
   logic [7:0] rst_a[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c};
   logic [31:0] rst_v[6] = '{32'h0000_08c0, 32'h0, 32'h0000_0008,
      32'h0000_0001, 32'h0000_00c8, 32'h0};
   // address, write value, read mask, expected read
   logic [103:0] cfg[14] = '{104'h08_0000_0000_ffff_ffff_0000_0008,
      104'h08_0000_0041_ffff_ffff_0000_0008,
      104'h08_0000_0040_ffff_ffff_0000_0040,
      104'h04_0000_003d_ffff_ffff_0000_003d,
      104'h0c_0000_0003_ffff_ffff_0000_0001,
      104'h14_0000_0000_0000_0002_0000_0002,
      104'h14_0000_0002_0000_0002_0000_0000,
      104'h0c_0000_0008_ffff_ffff_0000_0008,
      104'h10_0000_0063_ffff_ffff_0000_00c8,
      104'h00_0000_0300_0000_0000_0000_0000,
      104'h10_0000_010e_ffff_ffff_0000_00c8,
      104'h10_0000_010a_ffff_ffff_0000_010a,
      104'h00_0000_00c0_ffff_ffff_0000_00c0,
      104'h10_0000_0096_ffff_ffff_0000_0096};
   integer seed = 32'h83fa_22fb;
   int fail_count = 0;
   int check_count = 0;
   int got, i;

   ddr_io uut (.clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data_ff(rd_data_ff), .dqs_in(dqs_in),
      .dq_in(dq_in), .dq_out_ff(dq_out_ff), .dq_oe_n_ff(dq_oe_n_ff),
      .dqs_out_ff(dqs_out_ff), .dqs_oe_n_ff(dqs_oe_n_ff), .dqs_n_out_ff(),
      .dqs_n_oe_n_ff(), .cke(cke), .dq_ts(dq_ts), .dqs_ts(dqs_ts),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready_ff(tx_ready_ff),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
   ddr_pins_model pins (.dqs_in(dqs_in), .dq_in(dq_in));

   // 20 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      begin
         check_count++;
         if (g !== e)
         begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask

   task automatic give_verdict;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask

   // a wait that ran out counts as a mismatch and ends the run
   task automatic give_up;
      begin
         check(32'h0, 32'h1);
         give_verdict();
      end
   endtask

   // one idle cycle after each write avoids re-raising the strobe
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      begin
         addr <= a;
         wr_data <= d;
         wr_en <= 1'b1;
         @(posedge clk);
         wr_en <= 1'b0;
         @(posedge clk);
      end
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
      begin
         addr <= a;
         rd_en <= 1'b1;
         @(posedge clk);
         rd_en <= 1'b0;
         @(posedge clk);
         check(rd_data_ff & m, e);
      end
   endtask

   // one strobe frame; the model word is queued only when it should arrive
   task automatic pair(input logic [7:0] m, input bit keep);
      logic [7:0] r, f;
      begin
         r = 8'($random(seed));
         f = 8'($random(seed));
         if (keep)
            exp_q.push_back({16'h0000, f & m, r & m});
         pins.send_pair(r, f);
         @(posedge clk);
      end
   endtask

   task automatic drained;
      begin
         for (i = 0; i < 400 && exp_q.size() != 0; i++)
            @(posedge clk);
         if (exp_q.size() != 0)
            give_up();
      end
   endtask

   // hand over one word, then follow its bytes across strobe toggles
   task automatic send_word(input int n);
      logic d;
      int k;
      begin
         w = $random(seed);
         tx_data <= w;
         tx_valid <= 1'b1;
         i = 0;
         do
         begin
            @(posedge clk);
            i++;
         end
         while (tx_ready_ff !== 1'b1 && i < 100);
         if (i == 100)
            give_up();
         tx_valid <= 1'b0;
         // skip the accept edge so a tick there with no word is not followed
         @(posedge clk);
         for (k = 0; k < n; k++)
         begin
            d = dqs_out_ff;
            i = 0;
            do
            begin
               @(posedge clk);
               i++;
            end
            while (dqs_out_ff === d && i < 20);
            check({23'h0, dq_oe_n_ff, dq_out_ff}, {24'h0, w[8*k +: 8]});
         end
      end
   endtask

   // drain side with random stalls; each word taken is compared in order
   always @(posedge clk)
   begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
      begin
         got++;
         if (exp_q.size() == 0)
            check(rx_data, 32'hdead_beef);
         else
            check(rx_data, exp_q.pop_front());
      end
      rx_ready <= drain && ($random(seed) % 4 != 0);
   end

   // hang guard, well inside 100k cycles
   initial
   begin
      #4_000_000;
      give_up();
   end

   initial
   begin
      {wr_en, rd_en, cke, dq_ts, dqs_ts, tx_valid, rx_ready, drain} = '0;
      reset_n = 1'b0;
      addr = 8'h00;
      wr_data = '0;
      tx_data = '0;
      got = 0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      check({31'h0, tx_ready_ff}, 32'h0);
      for (i = 0; i < 6; i++)
         reg_rd(rst_a[i], 32'hffff_ffff, rst_v[i]);
      for (i = 0; i < 14; i++)
      begin
         reg_wr(cfg[i][103:96], cfg[i][95:64]);
         reg_rd(cfg[i][103:96], cfg[i][63:32], cfg[i][31:0]);
      end
      reg_rd(8'h14, 32'h0000_0008, 32'h0000_0008);
      $display("test registers done");
      // receive: narrowed width masks the upper lanes; tap 0 keeps data
      // centred on the strobe edges that the pins model sends
      reg_wr(8'h00, 32'h0000_08c0);
      reg_wr(8'h04, 32'h0000_0000);
      reg_wr(8'h08, 32'h0000_0004);
      drain <= 1'b1;
      repeat (4) pair(8'h0f, 1'b1);
      drained;
      reg_wr(8'h08, 32'h0000_0008);
      repeat (3) pair(8'hff, 1'b1);
      drained;
      // capture enable held low: nothing may arrive
      reg_wr(8'h00, 32'h0000_08e0);
      cke <= 1'b0;
      repeat (2) pair(8'hff, 1'b0);
      repeat (20) @(posedge clk);
      cke <= 1'b1;
      pair(8'hff, 1'b1);
      drained;
      $display("test receive done");
      // fill until refused, then drain to empty
      reg_wr(8'h00, 32'h0000_08c0);
      drain <= 1'b0;
      got = 0;
      repeat (11) pair(8'hff, 1'b1);
      repeat (8) @(posedge clk);
      reg_rd(8'h14, 32'h0000_0024, 32'h0000_0024);
      drain <= 1'b1;
      repeat (80) @(posedge clk);
      check({31'h0, got >= 8}, 32'h1);
      reg_rd(8'h14, 32'h0000_0010, 32'h0000_0010);
      exp_q.delete();
      $display("test fill done");
      // transmit 1x back to back, then 2x with tristate controls
      reg_wr(8'h00, 32'h0000_08c1);
      send_word(2);
      send_word(2);
      reg_wr(8'h00, 32'h0000_08c5);
      send_word(4);
      dq_ts <= 1'b1;
      dqs_ts <= 1'b1;
      repeat (3) @(posedge clk);
      check({30'h0, dq_oe_n_ff, dqs_oe_n_ff}, 32'h3);
      reg_wr(8'h00, 32'h0000_0805);
      send_word(4);
      check({31'h0, dqs_oe_n_ff}, 32'h0);
      $display("test transmit done");
      give_verdict();
   end
endmodule

bind ddr_io ddr_io_chk chk (.clk(clk), .reset_n(reset_n), .addr(addr),
   .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_ff(rd_data_ff),
   .dq_out_ff(dq_out_ff), .dqs_out_ff(dqs_out_ff), .tx_valid(tx_valid),
   .tx_ready_ff(tx_ready_ff), .rx_data(rx_data), .rx_valid(rx_valid),
   .rx_ready(rx_ready));
`default_nettype wire
